// ### common/dsr_pkg.sv
// Package with constants, types and the register map of the result output sequencer.
package dsr_pkg;
    // Conversion timing, in converter clock counts.
    localparam int CYCLE_LEN = 40002;
    localparam int AZ_HOLD_LEN = 10001;
    localparam int SI_LEN = 10000;
    localparam int RI_LIMIT = 20000;
    localparam int IZ_NORM_LEN = 200;
    localparam int IZ_OVER_LEN = 6200;
    localparam int LOW_COUNT_LIMIT = 1800;
    localparam int CNT_W = 16;

    // Digit scan timing.
    localparam int NUM_DIGITS = 5;
    localparam logic [2:0] LAST_DIGIT = 3'h4;
    localparam logic [2:0] STROBE_COUNT = 3'h5;
    localparam logic [7:0] TOP_DIGIT_END = 8'd200;
    localparam logic [7:0] DIGIT_END = 8'd199;
    localparam logic [7:0] TOP_STROBE_POS = 8'd101;
    localparam logic [7:0] STROBE_POS = 8'd100;

    // APB register map.
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_RESULT = 12'h008;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OVER_BIT = 1;
    localparam int STAT_LOW_BIT = 2;
    localparam int STAT_SIGN_BIT = 3;
    localparam int STAT_HOLD_BIT = 4;
    localparam int STAT_PHASE_LSB = 8;

    typedef enum logic [2:0] {PH_HOLD, PH_AZ, PH_SI, PH_RI, PH_IZ} dsr_phase_t;

    typedef struct packed {
        logic digit_sel_top;
        logic digit_sel_fourth;
        logic digit_sel_third;
        logic digit_sel_second;
        logic digit_sel_lowest;
        logic bcd_weight_eight;
        logic bcd_weight_four;
        logic bcd_weight_two;
        logic bcd_weight_one;
        logic strobe_n;
    } dsr_disp_t;

    typedef struct packed {
        logic busy;
        logic over_limit;
        logic low_count_flag;
        logic sign;
    } dsr_flags_t;

    typedef struct packed {
        logic auto_zero;
        logic sig_int;
        logic ref_int_pos;
        logic ref_int_neg;
        logic int_zero;
    } dsr_analog_t;
endpackage

// ### rtl/dsr_seq.sv
// Phase sequencer, result counter, digit scan and APB registers of the dual-slope converter.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module dsr_seq #(
    parameter int CYCLE_LEN_P = dsr_pkg::CYCLE_LEN,
    parameter int AZ_HOLD_LEN_P = dsr_pkg::AZ_HOLD_LEN,
    parameter int SI_LEN_P = dsr_pkg::SI_LEN,
    parameter int RI_LIMIT_P = dsr_pkg::RI_LIMIT,
    parameter int IZ_NORM_LEN_P = dsr_pkg::IZ_NORM_LEN,
    parameter int IZ_OVER_LEN_P = dsr_pkg::IZ_OVER_LEN,
    parameter int LOW_COUNT_LIMIT_P = dsr_pkg::LOW_COUNT_LIMIT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from the analog side and the user
    input wire logic run_hold,
    input wire logic zero_cross,
    input wire logic polarity_in,
    // Outputs
    output dsr_pkg::dsr_disp_t disp,
    output dsr_pkg::dsr_flags_t flags,
    output dsr_pkg::dsr_analog_t analog
);
    import dsr_pkg::*;

    localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(CYCLE_LEN_P - 1);
    localparam logic [CNT_W-1:0] AZ_HOLD_LAST = CNT_W'(AZ_HOLD_LEN_P - 1);
    localparam logic [CNT_W-1:0] SI_LAST = CNT_W'(SI_LEN_P - 1);
    localparam logic [CNT_W-1:0] RI_MAX = CNT_W'(RI_LIMIT_P);
    localparam logic [CNT_W-1:0] IZ_NORM_LAST = CNT_W'(IZ_NORM_LEN_P - 1);
    localparam logic [CNT_W-1:0] IZ_OVER_LAST = CNT_W'(IZ_OVER_LEN_P - 1);
    localparam logic [CNT_W-1:0] LOW_MAX = CNT_W'(LOW_COUNT_LIMIT_P);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // Adds one to a five-digit BCD number.
    function automatic logic [19:0] bcd_inc(input logic [19:0] v);
        logic [19:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            if (carry) begin
                if (r[i*4 +: 4] == 4'h9) begin
                    r[i*4 +: 4] = 4'h0;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Picks one digit of the result; index 0 is the most significant.
    function automatic logic [3:0] digit_of(input logic [19:0] v, input logic [2:0] idx);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            if (idx == 3'(i)) begin
                r = v[(NUM_DIGITS-1-i)*4 +: 4];
            end
        end
        return r;
    endfunction

    // Pin synchronisers: three stages, a change counts once stages two and three agree.
    logic [2:0] s1_q, s2_q, s3_q, pin_q, pin_d;
    logic run_prev_q;
    wire logic [2:0] pins_raw = {polarity_in, zero_cross, run_hold};
    assign pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
    wire logic run_f = pin_q[0];
    wire logic zc_f = pin_q[1];
    wire logic pol_f = pin_q[2];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            pin_q <= 3'h0;
            run_prev_q <= 1'b0;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
            run_prev_q <= run_f;
        end
    end

    // Register state.
    logic ctrl_run_q;
    logic start_q;
    logic [31:0] prdata_q;

    // Sequencer state.
    dsr_phase_t phase_q, phase_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] cyc_q, cyc_d;
    logic az_hold_q, az_hold_d;
    logic [CNT_W-1:0] ref_q;
    logic [19:0] bcd_cnt_q;
    logic [19:0] result_q;
    logic busy_q, over_q, low_q, sign_q, ov_pend_q, ld_q;

    wire logic run_level = run_f & ctrl_run_q;
    wire logic start_evt = (run_f & ~run_prev_q) | start_q;
    wire logic az_done = az_hold_q ? (cnt_q == AZ_HOLD_LAST) : (cyc_q == CYC_LAST);
    wire logic ri_counting = (phase_q == PH_RI) && (cnt_q != CNT_ZERO);
    wire logic ri_zero_hit = ri_counting && zc_f;
    wire logic ri_over_hit = ri_counting && !zc_f && (ref_q == RI_MAX);
    wire logic ri_end = ri_zero_hit || ri_over_hit;
    wire logic [CNT_W-1:0] iz_last = ov_pend_q ? IZ_OVER_LAST : IZ_NORM_LAST;
    wire logic si_enter = (phase_q != PH_SI) && (phase_d == PH_SI);
    wire logic ri_enter = (phase_q == PH_SI) && (phase_d == PH_RI);

    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q + CNT_ONE;
        cyc_d = cyc_q + CNT_ONE;
        az_hold_d = az_hold_q;
        unique case (phase_q)
            PH_HOLD: begin
                cnt_d = CNT_ZERO;
                cyc_d = CNT_ZERO;
                if (run_level || start_evt) begin
                    phase_d = PH_AZ;
                    az_hold_d = 1'b1;
                end
            end
            PH_AZ: begin
                if (az_done) begin
                    cnt_d = CNT_ZERO;
                    cyc_d = CNT_ZERO;
                    az_hold_d = 1'b0;
                    if (az_hold_q || run_level) begin
                        phase_d = PH_SI;
                    end else begin
                        phase_d = PH_HOLD;
                    end
                end
            end
            PH_SI: begin
                if (cnt_q == SI_LAST) begin
                    phase_d = PH_RI;
                    cnt_d = CNT_ZERO;
                end
            end
            PH_RI: begin
                if (ri_end) begin
                    phase_d = PH_IZ;
                    cnt_d = CNT_ZERO;
                end
            end
            PH_IZ: begin
                if (cnt_q == iz_last) begin
                    phase_d = PH_AZ;
                    cnt_d = CNT_ZERO;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_q <= PH_HOLD;
            cnt_q <= CNT_ZERO;
            cyc_q <= CNT_ZERO;
            az_hold_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            cyc_q <= cyc_d;
            az_hold_q <= az_hold_d;
        end
    end

    // Reference count: the first deintegrate clock is skipped to offset the zero-crossing delay.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_q <= CNT_ZERO;
            bcd_cnt_q <= 20'h0_0000;
        end else if (ri_enter) begin
            ref_q <= CNT_ZERO;
            bcd_cnt_q <= 20'h0_0000;
        end else if (ri_counting && !ri_end) begin
            ref_q <= ref_q + CNT_ONE;
            bcd_cnt_q <= bcd_inc(bcd_cnt_q);
        end
    end

    // Busy, latch strobe and status flags.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            ov_pend_q <= 1'b0;
            ld_q <= 1'b0;
            result_q <= 20'h0_0000;
            over_q <= 1'b0;
            low_q <= 1'b0;
            sign_q <= 1'b0;
        end else begin
            ld_q <= ri_end;
            if (si_enter) begin
                busy_q <= 1'b1;
            end else if (ri_end) begin
                busy_q <= 1'b0;
            end
            if (ri_end) begin
                ov_pend_q <= ri_over_hit;
            end
            if (ld_q) begin
                result_q <= bcd_cnt_q;
                over_q <= ov_pend_q;
                low_q <= !ov_pend_q && (ref_q <= LOW_MAX);
            end else begin
                if (ri_enter) begin
                    over_q <= 1'b0;
                end
                if (si_enter) begin
                    low_q <= 1'b0;
                end
            end
            if (ri_enter) begin
                sign_q <= pol_f;
            end
        end
    end

    // Digit scan and transfer pulses.
    logic [2:0] dig_q;
    logic [7:0] pos_q;
    logic [2:0] strobes_left_q;
    logic blank_q;
    wire logic [7:0] pos_end = (dig_q == 3'h0) ? TOP_DIGIT_END : DIGIT_END;
    wire logic [7:0] strobe_pos = (dig_q == 3'h0) ? TOP_STROBE_POS : STROBE_POS;
    wire logic strobe_now = (strobes_left_q != 3'h0) && (pos_q == strobe_pos);
    wire logic last_strobe = strobe_now && (strobes_left_q == 3'h1);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dig_q <= 3'h0;
            pos_q <= 8'h00;
            strobes_left_q <= 3'h0;
            blank_q <= 1'b0;
        end else if (ld_q) begin
            dig_q <= 3'h0;
            pos_q <= 8'h00;
            strobes_left_q <= STROBE_COUNT;
            blank_q <= 1'b0;
        end else if (ri_enter && blank_q) begin
            // The repeated scan after an overrange blank starts again at the top digit.
            dig_q <= 3'h0;
            pos_q <= 8'h00;
            blank_q <= 1'b0;
        end else begin
            if (pos_q == pos_end) begin
                pos_q <= 8'h00;
                dig_q <= (dig_q == LAST_DIGIT) ? 3'h0 : dig_q + 3'h1;
            end else begin
                pos_q <= pos_q + 8'h01;
            end
            if (strobe_now) begin
                strobes_left_q <= strobes_left_q - 3'h1;
            end
            if (last_strobe && over_q) begin
                blank_q <= 1'b1;
            end
        end
    end

    // Registered display outputs; selects and data move on the same edge.
    wire logic [4:0] sel_onehot = 5'h10 >> dig_q;
    // Selects drop for the load clock so the top digit always rises at the end of a measurement.
    wire logic [4:0] sel_out = (blank_q || ld_q) ? 5'h00 : sel_onehot;
    wire logic [3:0] data_out = over_q ? 4'h0 : digit_of(result_q, dig_q);
    dsr_disp_t disp_q;
    dsr_analog_t analog_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            disp_q <= '{default: 1'b0, strobe_n: 1'b1};
            analog_q <= '0;
        end else begin
            disp_q <= {sel_out, data_out, ~strobe_now};
            analog_q.auto_zero <= (phase_d == PH_AZ);
            analog_q.sig_int <= (phase_d == PH_SI);
            analog_q.ref_int_pos <= (phase_d == PH_RI) && (ri_enter ? pol_f : sign_q);
            analog_q.ref_int_neg <= (phase_d == PH_RI) && !(ri_enter ? pol_f : sign_q);
            analog_q.int_zero <= (phase_d == PH_IZ);
        end
    end

    assign disp = disp_q;
    assign analog = analog_q;
    assign flags = '{busy: busy_q, over_limit: over_q, low_count_flag: low_q, sign: sign_q};

    // APB slave: zero wait states, read data prepared in the setup cycle.
    wire logic hit_ctrl = (paddr == REG_CTRL);
    wire logic hit_status = (paddr == REG_STATUS);
    wire logic hit_result = (paddr == REG_RESULT);
    wire logic mapped = hit_ctrl || hit_status || hit_result;
    wire logic setup = psel && !penable;
    wire logic wr_ctrl = psel && penable && pwrite && hit_ctrl;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux[CTRL_RUN_BIT] = ctrl_run_q;
        end
        if (hit_status) begin
            rd_mux[STAT_BUSY_BIT] = busy_q;
            rd_mux[STAT_OVER_BIT] = over_q;
            rd_mux[STAT_LOW_BIT] = low_q;
            rd_mux[STAT_SIGN_BIT] = sign_q;
            rd_mux[STAT_HOLD_BIT] = (phase_q == PH_HOLD);
            rd_mux[STAT_PHASE_LSB +: 3] = phase_q;
        end
        if (hit_result) begin
            rd_mux[19:0] = result_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_run_q <= CTRL_RUN_RESET;
            start_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            start_q <= wr_ctrl && pwdata[CTRL_START_BIT];
            if (wr_ctrl) begin
                ctrl_run_q <= pwdata[CTRL_RUN_BIT];
            end
            if (setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
endmodule

// ### dv/dsr_seq_checker.sv
// Concurrent checks on the ports of the result output sequencer.
`timescale 1ns/1ps
module dsr_seq_checker import dsr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic run_hold,
    input wire logic zero_cross,
    input wire logic polarity_in,
    input wire dsr_pkg::dsr_disp_t disp,
    input wire dsr_pkg::dsr_flags_t flags,
    input wire dsr_pkg::dsr_analog_t analog
);
    wire [4:0] sel = {disp.digit_sel_top, disp.digit_sel_fourth, disp.digit_sel_third,
        disp.digit_sel_second, disp.digit_sel_lowest};
    wire [3:0] bcd = {disp.bcd_weight_eight, disp.bcd_weight_four, disp.bcd_weight_two,
        disp.bcd_weight_one};
    logic [7:0] top_cnt_q;
    logic [2:0] stb_cnt_q;
    logic seen_q;

    // Strobes are counted from each result, so a sixth one shows up.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            top_cnt_q <= 8'h00;
            stb_cnt_q <= 3'h0;
            seen_q <= 1'b0;
        end else begin
            top_cnt_q <= disp.digit_sel_top ? top_cnt_q + 8'h01 : 8'h00;
            stb_cnt_q <= $fell(flags.busy) ? 3'h0 : stb_cnt_q + {2'h0, !disp.strobe_n};
            seen_q <= seen_q | $fell(flags.busy);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_top_strobe;
        !disp.strobe_n && disp.digit_sel_top;
    endsequence

    chk_top_strobe_pos: assert property (s_top_strobe |-> $past(disp.digit_sel_top, 101) &&
        !$past(disp.digit_sel_top, 102)) else $error("top digit strobe misplaced");
    chk_digit_strobe_pos: assert property (!disp.strobe_n && !disp.digit_sel_top |->
        sel == $past(sel, 100) && sel != $past(sel, 101)) else $error("digit strobe misplaced");
    chk_top_width: assert property ($fell(disp.digit_sel_top) && sel == 5'h08 |-> top_cnt_q == 8'd201)
        else $error("top digit width wrong");
    chk_iz_follows: assert property ($fell(analog.ref_int_pos || analog.ref_int_neg) |-> analog.int_zero)
        else $error("integrator zero did not follow reference integrate");
    chk_strobe_limit: assert property (!disp.strobe_n |-> stb_cnt_q < 3'h5)
        else $error("extra strobe");
    chk_five_strobes: assert property ($rose(flags.busy) && seen_q |-> stb_cnt_q == 3'h5)
        else $error("strobe count wrong");
    chk_scan_order: assert property (sel != $past(sel) && sel != 5'h00 && $past(sel) != 5'h00
        |-> sel == ($past(sel) >> 1) || sel == 5'h10) else $error("scan order wrong");
    chk_over_blank: assert property (flags.over_limit && stb_cnt_q == 3'h5 &&
        $past(stb_cnt_q) == 3'h5 |-> sel == 5'h00) else $error("overrange not blanked");
    chk_bcd_zero: assert property (flags.over_limit && $past(flags.over_limit) |-> bcd == 4'h0)
        else $error("bcd not zero");
    chk_busy_az: assert property (analog.auto_zero |-> !flags.busy)
        else $error("busy in auto-zero");
    chk_busy_start: assert property ($rose(flags.busy) |-> analog.sig_int)
        else $error("busy rose outside signal integrate");
    chk_sign_hold: assert property ($changed(flags.sign) |->
        $rose(analog.ref_int_pos | analog.ref_int_neg)) else $error("sign changed late");
endmodule

bind dsr_seq dsr_seq_checker i_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_hold(run_hold), .zero_cross(zero_cross),
    .polarity_in(polarity_in), .disp(disp), .flags(flags), .analog(analog));

// ### dv/dsr_far_model.sv
// Far side model: analog comparators plus a strobe-driven digit latch.
`timescale 1ns/1ps
module dsr_far_model import dsr_pkg::*; (
    // Clock
    input wire logic clk,
    // From the sequencer
    input wire dsr_pkg::dsr_disp_t disp,
    input wire dsr_pkg::dsr_analog_t analog,
    // Commanded input
    input wire logic [15:0] tgt,
    input wire logic pol,
    // To the sequencer and the bench
    output logic zero_cross,
    output logic polarity_in,
    output logic [19:0] digits,
    output int nstb
);
    logic [15:0] ri_cnt;
    wire ri = analog.ref_int_pos | analog.ref_int_neg;

    // The integrator crosses zero after tgt counts; a huge tgt never crosses.
    assign zero_cross = ri && ri_cnt >= tgt;
    assign polarity_in = pol;

    initial begin
        ri_cnt = 16'h0000;
        digits = 20'h0_0000;
        nstb = 0;
    end

    always @(posedge clk) begin
        ri_cnt <= ri ? ri_cnt + 16'h0001 : 16'h0000;
        if (!disp.strobe_n) begin
            nstb <= nstb + 1;
            for (int i = 0; i < 5; i++) begin
                if (disp[9-i]) begin
                    digits[19-4*i -: 4] <= disp[4:1];
                end
            end
        end
    end
endmodule

// ### dv/tb_top.sv
// Self-checking testbench of the result output sequencer.
`timescale 1ns/1ps
module tb_top;
    import dsr_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, run_hold, pol, err, pready, pslverr;
    logic zero_cross, polarity_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [15:0] tgt;
    logic [19:0] digits;
    dsr_disp_t disp;
    dsr_flags_t flags;
    dsr_analog_t analog;
    int nstb, err_count, tests_run, cyc, seed, n, k, cnt;
    logic ovr;
    // Shortened counts; auto-zero after hold and the normal integrator zero keep full length.
    localparam int RI_LIM_TB = 200;
    localparam int LOW_LIM_TB = 18;

    dsr_seq #(.CYCLE_LEN_P(1400), .SI_LEN_P(100), .RI_LIMIT_P(RI_LIM_TB), .IZ_OVER_LEN_P(62),
        .LOW_COUNT_LIMIT_P(LOW_LIM_TB)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_hold(run_hold), .zero_cross(zero_cross), .polarity_in(polarity_in),
        .disp(disp), .flags(flags), .analog(analog));
    dsr_far_model i_far (.clk(clk), .disp(disp), .analog(analog), .tgt(tgt), .pol(pol),
        .zero_cross(zero_cross), .polarity_in(polarity_in), .digits(digits), .nstb(nstb));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Converts a count to five BCD digits, least significant digit in the low nibble.
    function automatic logic [19:0] to_bcd(input int v);
        logic [19:0] b;
        b = 20'h0_0000;
        for (int i = 0; i < 5; i++) begin
            b[i*4 +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return b;
    endfunction

    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_busy(input logic v);
        k = 0;
        while (flags.busy !== v && k < AZ_HOLD_LEN + 3000) begin
            @(posedge clk);
            k++;
        end
        chk("busy", flags.busy, v);
    endtask

    // A target above the reference limit never crosses zero.
    task measure(input int t, input logic p, input logic drop);
        wait_busy(1'b1);
        tgt <= t[15:0];
        pol <= p;
        if (drop) run_hold <= 1'b0;
        wait_busy(1'b0);
        n = nstb;
        k = 0;
        while (nstb < n + 5 && k < 1200) begin
            @(posedge clk);
            k++;
        end
        chk("strobes", nstb - n, 5);
        // Reading is the target plus the four-clock pin filter, less the skipped first count.
        cnt = t + 3;
        ovr = cnt > RI_LIM_TB;
        apb(1'b0, REG_RESULT, 32'h0000_0000);
        chk("result", rd[19:0], to_bcd(ovr ? RI_LIM_TB : cnt));
        chk("digits", digits, ovr ? 20'h0_0000 : to_bcd(cnt));
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk("over", rd[STAT_OVER_BIT], ovr);
        chk("low", rd[STAT_LOW_BIT], !ovr && cnt <= LOW_LIM_TB);
        chk("sign", rd[STAT_SIGN_BIT], p);
        chk("over pin", flags.over_limit, ovr);
        chk("low pin", flags.low_count_flag, !ovr && cnt <= LOW_LIM_TB);
        chk("sign pin", flags.sign, p);
        $display("measurement with target %0d done", t);
    endtask

    task idle_check;
        n = 0;
        repeat (1500) begin
            @(posedge clk);
            n += int'(flags.busy !== 1'b0);
        end
        chk("hold idle", n, 0);
        $display("hold idle test done");
    endtask

    initial begin
        seed = 4642;
        cyc = 0;
        err_count = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        run_hold = 1'b1;
        tgt = 16'h0020;
        pol = 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b1, 12'h0FC, 32'h0000_0000);
        chk("unmapped error", err, 1'b1);
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        chk("run enable", rd[CTRL_RUN_BIT], CTRL_RUN_RESET);
        measure(3, 1'b0, 1'b0);
        measure(999, 1'b1, 1'b0);
        measure(999, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            r = $random(seed);
            measure(r[1:0] == 2'h0 ? 999 : (r[2] ? 3 + r[5:3] : 30 + r[13:7]), r[14], 1'b0);
        end
        measure(15, 1'b1, 1'b0);
        measure(16, 1'b0, 1'b0);
        measure(100, 1'b1, 1'b1);
        idle_check;
        run_hold <= 1'b1;
        repeat (8) @(posedge clk);
        run_hold <= 1'b0;
        n = 8;
        while (flags.busy !== 1'b1 && n < AZ_HOLD_LEN + 400) begin
            @(posedge clk);
            n++;
        end
        chk("auto-zero length", n >= AZ_HOLD_LEN && n <= AZ_HOLD_LEN + 20, 1'b1);
        measure(60, 1'b1, 1'b0);
        idle_check;
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        chk("run enable off", rd[CTRL_RUN_BIT], 1'b0);
        chk("start reads zero", rd[CTRL_START_BIT], 1'b0);
        r = $random(seed);
        measure(30 + int'(r[6:0]), r[7], 1'b0);
        wrap_up;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 65000) begin
            err_count++;
            wrap_up;
        end
    end
endmodule
